// ---- rtl/embp_port.sv ----
// Purpose: external static memory, io and nand bus port
// Assumes: requests synchronous to clk_sys; one access at a time
// Notes:   data bus given as in/out/enable; nand uses low byte lane
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module embp_port #(
   parameter logic [3:0] ACCESS_LEN = embp_pkg::DEF_ACCESS_LEN,
   parameter logic [3:0] NAND_LEN   = embp_pkg::DEF_NAND_LEN
) (
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   input  wire logic                           req_valid,
   output logic                                req_ready,
   input  wire logic [1:0]                     req_target,
   input  wire logic [1:0]                     req_bank,
   input  wire logic [1:0]                     req_nand_phase,
   input  wire logic                           req_write,
   input  wire logic [1:0]                     req_byte_en,
   input  wire logic [embp_pkg::ADDR_W-1:0]    req_addr,
   input  wire logic [embp_pkg::DATA_W-1:0]    req_wdata,
   input  wire logic                           bus_8bit,
   input  wire logic [1:0]                     mem_map,
   input  wire logic                           boot_from_nand,
   output logic                                boot_target_nand,
   output logic                                rsp_valid,
   output logic [embp_pkg::DATA_W-1:0]         rsp_rdata,
   output logic [embp_pkg::ADDR_W-1:0]         ext_address_bus,
   input  wire logic [embp_pkg::DATA_W-1:0]    ext_data_bus_in,
   output logic [embp_pkg::DATA_W-1:0]         ext_data_bus_out,
   output logic                                ext_data_bus_oe,
   output logic [embp_pkg::IO_BANKS-1:0]       io_bank_selects_n,
   output logic                                mem_bank1_select_n,
   output logic                                mem_bank0_select_n,
   input  wire logic                           target_wait_n,
   output logic                                read_output_enable_n,
   output logic                                upper_byte_write_n,
   output logic                                lower_byte_write_n,
   output logic                                nand_command_latch,
   output logic                                nand_address_latch,
   output logic                                nand_bank1_enable_n,
   output logic                                nand_bank0_enable_n
);
   embp_pkg::embp_state_t state_r, state_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [1:0]  tgt_r, tgt_nxt;
   logic [1:0]  bank_r, bank_nxt;
   logic [1:0]  phase_r, phase_nxt;
   logic        wr_r, wr_nxt;
   logic [1:0]  be_r, be_nxt;
   logic        w8_r, w8_nxt;
   logic [embp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
   logic [embp_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
   logic [embp_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
   logic        rsp_r, rsp_nxt;
   logic        boot_r, boot_nxt;
   logic        boot_done_r, boot_done_nxt;
   logic        active;
   logic        is_nand;
   logic        stretch;
   logic [1:0]  mem_sel_n;
   logic [1:0]  nand_sel_n;

   ////////////////////////////////////////////////////////////////////
   // strap capture after reset release
   always_comb begin
      boot_nxt      = boot_done_r ? boot_r : boot_from_nand;
      boot_done_nxt = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         boot_r      <= 1'b0;
         boot_done_r <= 1'b0;
      end else begin
         boot_r      <= boot_nxt;
         boot_done_r <= boot_done_nxt;
      end
   end

   assign boot_target_nand = boot_r;

   ////////////////////////////////////////////////////////////////////
   // access sequencer
   assign active  = (state_r == embp_pkg::EMBP_ACCESS) ||
                    (state_r == embp_pkg::EMBP_WAITING);
   assign is_nand = (tgt_r == 2'(embp_pkg::EMBP_TGT_NAND));
   // wait only honoured for static and io targets
   assign stretch = !is_nand && !target_wait_n;
   assign req_ready = (state_r == embp_pkg::EMBP_IDLE);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      tgt_nxt   = tgt_r;
      bank_nxt  = bank_r;
      phase_nxt = phase_r;
      wr_nxt    = wr_r;
      be_nxt    = be_r;
      w8_nxt    = w8_r;
      addr_nxt  = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      rsp_nxt   = 1'b0;
      case (state_r)
         embp_pkg::EMBP_IDLE: begin
            if (req_valid) begin
               state_nxt = embp_pkg::EMBP_ACCESS;
               tgt_nxt   = req_target;
               bank_nxt  = req_bank;
               phase_nxt = req_nand_phase;
               wr_nxt    = req_write ||
                  req_nand_phase != 2'(embp_pkg::EMBP_NAND_DATA) &&
                  req_target == 2'(embp_pkg::EMBP_TGT_NAND);
               be_nxt    = req_byte_en;
               w8_nxt    = bus_8bit ||
                           req_target == 2'(embp_pkg::EMBP_TGT_NAND);
               addr_nxt  = (req_target == 2'(embp_pkg::EMBP_TGT_IO)) ?
                  {{(embp_pkg::ADDR_W-embp_pkg::IO_SPAN_W){1'b0}},
                   req_addr[embp_pkg::IO_SPAN_W-1:0]} : req_addr;
               wdata_nxt = req_wdata;
               cnt_nxt   = (req_target == 2'(embp_pkg::EMBP_TGT_NAND)) ?
                           NAND_LEN : ACCESS_LEN;
            end
         end
         embp_pkg::EMBP_ACCESS: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (stretch) begin
               state_nxt = embp_pkg::EMBP_WAITING;
            end else begin
               state_nxt = embp_pkg::EMBP_RECOVER;
               rdata_nxt = w8_r ? {8'h00, ext_data_bus_in[7:0]}
                                : ext_data_bus_in;
               rsp_nxt   = 1'b1;
            end
         end
         embp_pkg::EMBP_WAITING: begin
            if (!stretch) begin
               state_nxt = embp_pkg::EMBP_RECOVER;
               rdata_nxt = w8_r ? {8'h00, ext_data_bus_in[7:0]}
                                : ext_data_bus_in;
               rsp_nxt   = 1'b1;
            end
         end
         embp_pkg::EMBP_RECOVER: begin
            state_nxt = embp_pkg::EMBP_IDLE;
         end
         default: state_nxt = embp_pkg::EMBP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= embp_pkg::EMBP_IDLE;
         cnt_r   <= 4'h0;
         tgt_r   <= 2'h0;
         bank_r  <= 2'h0;
         phase_r <= 2'h0;
         wr_r    <= 1'b0;
         be_r    <= 2'h0;
         w8_r    <= 1'b0;
         addr_r  <= '0;
         wdata_r <= '0;
         rdata_r <= '0;
         rsp_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         tgt_r   <= tgt_nxt;
         bank_r  <= bank_nxt;
         phase_r <= phase_nxt;
         wr_r    <= wr_nxt;
         be_r    <= be_nxt;
         w8_r    <= w8_nxt;
         addr_r  <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         rsp_r   <= rsp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin drive
   embp_select_decode u_dec (
      .active     (active),
      .target     (tgt_r),
      .bank       (bank_r),
      .mem_map    (mem_map),
      .mem_sel_n  (mem_sel_n),
      .io_sel_n   (io_bank_selects_n),
      .nand_sel_n (nand_sel_n)
   );

   assign mem_bank0_select_n   = mem_sel_n[0];
   assign mem_bank1_select_n   = mem_sel_n[1];
   assign nand_bank0_enable_n  = nand_sel_n[0];
   assign nand_bank1_enable_n  = nand_sel_n[1];
   assign ext_address_bus      = addr_r;
   assign ext_data_bus_out     = wdata_r;
   assign ext_data_bus_oe      = active && wr_r;
   assign read_output_enable_n = ~(active && !wr_r);
   assign upper_byte_write_n   = ~(active && wr_r && !w8_r && be_r[1]);
   assign lower_byte_write_n   = ~(active && wr_r && be_r[0]);
   assign nand_command_latch   = active && is_nand &&
      phase_r == 2'(embp_pkg::EMBP_NAND_CMD);
   assign nand_address_latch   = active && is_nand &&
      phase_r == 2'(embp_pkg::EMBP_NAND_ADDR);
   assign rsp_valid            = rsp_r;
   assign rsp_rdata            = rdata_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_wait_low;
      state_r == embp_pkg::EMBP_ACCESS && cnt_r == 4'h0 && stretch;
   endsequence

   one_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $onehot0({~mem_sel_n, ~io_bank_selects_n, ~nand_sel_n}))
      else $error("more than one select low");
   wait_stretch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_wait_low |=> state_r == embp_pkg::EMBP_WAITING && !rsp_valid)
      else $error("wait did not stretch access");
   oe_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !read_output_enable_n |-> !ext_data_bus_oe)
      else $error("output enable during drive");
   upper_8bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      w8_r |-> upper_byte_write_n)
      else $error("upper strobe in 8-bit mode");
   lower_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !lower_byte_write_n |-> ext_data_bus_oe)
      else $error("lower strobe without drive");
   cmd_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      nand_command_latch |-> ext_data_bus_oe && !nand_address_latch)
      else $error("command latch without data");
   addr_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      nand_address_latch |-> ext_data_bus_oe &&
      (!nand_bank0_enable_n || !nand_bank1_enable_n))
      else $error("address latch bad");
   nand_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !nand_bank1_enable_n |-> bank_r == 2'h1 && is_nand)
      else $error("wrong nand bank");
   share_bus_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      req_valid && req_ready |=> !req_ready [*2])
      else $error("bus taken twice");
   io_span_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      io_bank_selects_n != 3'h7 |-> ext_address_bus[23:14] == 10'h000)
      else $error("io address beyond bank");
   boot_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      boot_done_r |=> $stable(boot_target_nand))
      else $error("boot choice changed");
   mem_bank_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !mem_bank0_select_n |-> !is_nand && tgt_r == 2'h0)
      else $error("memory select on wrong target");
   addr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      active && $past(active) |-> $stable(ext_address_bus))
      else $error("address moved mid access");
   width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rsp_valid && w8_r |-> rsp_rdata[15:8] == 8'h00)
      else $error("8-bit read upper byte set");
endmodule : embp_port

// ---- shared/embp_pkg.sv ----
// Purpose: constants and types for the external memory bus port
// Assumes: 100 MHz clk_sys
// Notes:   cycle counts are in clk_sys periods
package embp_pkg;
   localparam int ADDR_W      = 24;
   localparam int DATA_W      = 16;
   localparam int IO_BANKS    = 3;
   localparam int MEM_BANKS   = 2;
   localparam int NAND_BANKS  = 2;
   localparam int IO_SPAN_W   = 14;   // 16 kbytes per io bank
   localparam int LEN_W       = 4;
   localparam logic [3:0] DEF_ACCESS_LEN = 4'h3;
   localparam logic [3:0] DEF_NAND_LEN   = 4'h2;
   localparam logic [1:0] MAP_DIRECT     = 2'h0;
   localparam logic [1:0] MAP_SWAP       = 2'h1;

   typedef enum logic [1:0] {
      EMBP_TGT_MEM,
      EMBP_TGT_IO,
      EMBP_TGT_NAND
   } embp_target_t;

   typedef enum logic [1:0] {
      EMBP_NAND_DATA,
      EMBP_NAND_CMD,
      EMBP_NAND_ADDR
   } embp_nand_phase_t;

   typedef enum {
      EMBP_IDLE,
      EMBP_ACCESS,
      EMBP_WAITING,
      EMBP_RECOVER
   } embp_state_t;
endpackage : embp_pkg

// ---- rtl/embp_select_decode.sv ----
// Purpose: one-hot select decoder for memory, io and nand banks
// Assumes: request fields held stable while decoding
// Notes:   outputs active low, at most one low
`timescale 1ns/100ps
module embp_select_decode (
   input  wire logic                   active,
   input  wire logic [1:0]             target,
   input  wire logic [1:0]             bank,
   input  wire logic [1:0]             mem_map,
   output logic [embp_pkg::MEM_BANKS-1:0]  mem_sel_n,
   output logic [embp_pkg::IO_BANKS-1:0]   io_sel_n,
   output logic [embp_pkg::NAND_BANKS-1:0] nand_sel_n
);
   logic [1:0] mem_bank;

   always_comb begin
      mem_bank = (mem_map == embp_pkg::MAP_SWAP) ? {bank[1], ~bank[0]}
                                                 : bank;
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sel
         if (g < embp_pkg::MEM_BANKS) begin : g_mem
            assign mem_sel_n[g] = ~(active &&
               target == 2'(embp_pkg::EMBP_TGT_MEM) &&
               mem_bank == 2'(g));
         end
         if (g < embp_pkg::IO_BANKS) begin : g_io
            assign io_sel_n[g] = ~(active &&
               target == 2'(embp_pkg::EMBP_TGT_IO) &&
               bank == 2'(g));
         end
         if (g < embp_pkg::NAND_BANKS) begin : g_nand
            assign nand_sel_n[g] = ~(active &&
               target == 2'(embp_pkg::EMBP_TGT_NAND) &&
               bank == 2'(g));
         end
      end
   endgenerate
endmodule : embp_select_decode

// ---- dv/embp_far_model.sv ----
// Purpose: far-side static target model for the external bus port
// Assumes: data wire has a pull-up; wait counted from select low
// Notes:   read data is a pattern of the low address byte
`timescale 1ns/100ps
module embp_far_model (
   input  wire logic                        clk_sys,
   input  wire logic [embp_pkg::ADDR_W-1:0] ext_address_bus,
   input  wire logic [embp_pkg::DATA_W-1:0] ext_data_bus_out,
   input  wire logic                        ext_data_bus_oe,
   input  wire logic [2:0]                  io_bank_selects_n,
   input  wire logic                        mem_bank1_select_n,
   input  wire logic                        mem_bank0_select_n,
   input  wire logic                        read_output_enable_n,
   input  wire logic [3:0]                  wait_len,
   output logic                             target_wait_n,
   output logic [embp_pkg::DATA_W-1:0]      ext_data_bus_in
);
   logic       sel;
   logic [3:0] cnt_r;
   assign sel = ~&{io_bank_selects_n, mem_bank1_select_n, mem_bank0_select_n};
   always_ff @(posedge clk_sys) begin
      cnt_r <= sel ? cnt_r + 4'h1 : 4'h0;
   end
   // slow target holds wait low for wait_len cycles
   assign target_wait_n = !(sel && cnt_r < wait_len);
   // wire level: device, target under output enable, else pull-up
   assign ext_data_bus_in = ext_data_bus_oe ? ext_data_bus_out :
      (sel && !read_output_enable_n) ?
      {~ext_address_bus[7:0], ext_address_bus[7:0]} : 16'hffff;
endmodule : embp_far_model

// ---- dv/embp_port_tb_top.sv ----
// Purpose: self-checking bench for the external bus port
// Assumes: inputs change on rising edge; outputs sampled at falling edge
// Notes:   latency counted in edges after the taking edge
`timescale 1ns/100ps
module embp_port_tb_top;
   typedef struct packed {
      logic [1:0] tg, bk, ph;
      logic       wr;
      logic [1:0] be;
      logic       b8, mp;
      logic [6:0] sel;
      logic [4:0] stb;
   } embp_row_t;
   localparam logic [3:0] ACL = 4'h4;
   localparam logic [3:0] NDL = 4'h2;
   logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [1:0] req_target = '0, req_bank = '0, req_nand_phase = '0;
   logic [1:0] req_byte_en = '0, mem_map = '0;
   logic bus_8bit = 1'b0, boot_from_nand = 1'b1;
   logic [23:0] req_addr = '0;
   logic [15:0] req_wdata = '0, dout, din, rsp_rdata;
   logic [3:0] wait_len = '0;
   logic req_ready, boot_target_nand, rsp_valid, doe, twait_n;
   logic [2:0] iosel;
   logic m1, m0, oe_n, ub_n, lb_n, cle, ale, n1, n0;
   logic [23:0] abus;
   logic [11:0] pins;
   int err_total = 0, total_checks = 0;
   embp_row_t rows [10] = '{
      '{0,0,0,0,3,0,0,7'h7b,5'h0c}, '{0,1,0,1,3,0,0,7'h77,5'h10},
      '{0,0,0,0,3,0,1,7'h77,5'h0c}, '{1,0,0,0,3,0,0,7'h6f,5'h0c},
      '{1,1,0,1,1,0,0,7'h5f,5'h18}, '{1,2,0,1,2,0,0,7'h3f,5'h14},
      '{0,0,0,1,3,1,0,7'h7b,5'h18}, '{0,1,0,0,3,1,0,7'h77,5'h0c},
      '{2,0,1,1,1,0,0,7'h7e,5'h1a}, '{2,1,2,1,1,0,0,7'h7d,5'h19}};
   assign pins = {iosel, m1, m0, n1, n0, oe_n, ub_n, lb_n, cle, ale};
   always #5 clk_sys = ~clk_sys;
   embp_port #(.ACCESS_LEN(ACL), .NAND_LEN(NDL)) embp_port_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_target(req_target), .req_bank(req_bank),
      .req_nand_phase(req_nand_phase), .req_write(req_write),
      .req_byte_en(req_byte_en), .req_addr(req_addr),
      .req_wdata(req_wdata), .bus_8bit(bus_8bit), .mem_map(mem_map),
      .boot_from_nand(boot_from_nand), .boot_target_nand(boot_target_nand),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_address_bus(abus),
      .ext_data_bus_in(din), .ext_data_bus_out(dout), .ext_data_bus_oe(doe),
      .io_bank_selects_n(iosel), .mem_bank1_select_n(m1),
      .mem_bank0_select_n(m0), .target_wait_n(twait_n),
      .read_output_enable_n(oe_n), .upper_byte_write_n(ub_n),
      .lower_byte_write_n(lb_n), .nand_command_latch(cle),
      .nand_address_latch(ale), .nand_bank1_enable_n(n1),
      .nand_bank0_enable_n(n0));
   embp_far_model embp_far_model_i (
      .clk_sys(clk_sys), .ext_address_bus(abus), .ext_data_bus_out(dout),
      .ext_data_bus_oe(doe), .io_bank_selects_n(iosel),
      .mem_bank1_select_n(m1), .mem_bank0_select_n(m0),
      .read_output_enable_n(oe_n), .wait_len(wait_len),
      .target_wait_n(twait_n), .ext_data_bus_in(din));
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic chk_pins(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t pins got %h exp %h", $time, got, exp);
      end
   endtask : chk_pins
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t value got %h exp %h", $time, got, exp);
      end
   endtask : chk_val
   // one access: drive, check strobes mid-access, latency and read data
   task automatic go(input embp_row_t r, input logic [23:0] a,
                     input logic [15:0] d, input logic [3:0] ext);
      int          n;
      logic [3:0]  len;
      logic [15:0] m;
      len = (r.tg == 2'h2) ? NDL : ACL;
      m = (r.b8 || r.tg == 2'h2) ? 16'h00ff : 16'hffff;
      @(negedge clk_sys);
      chk_val(req_ready, 1'b1);
      @(posedge clk_sys);
      {req_target, req_bank, req_nand_phase} <= {r.tg, r.bk, r.ph};
      {req_write, req_byte_en, bus_8bit} <= {r.wr, r.be, r.b8};
      mem_map <= {1'b0, r.mp};
      {req_addr, req_wdata, req_valid} <= {a, d, 1'b1};
      wait_len <= (ext == 4'h0) ? 4'h0 : len + ext;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk_pins(pins, {r.sel, r.stb});
      chk_val(req_ready, 1'b0);
      if (r.tg != 2'h2)
         chk_val(abus, (r.tg == 2'h1) ? {10'h0, a[13:0]} : a);
      chk_val(doe, r.wr);
      if (r.wr) chk_val(dout & m, d & m);
      n = 2;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      chk_val(24'(n), 24'(len + 4'h2 + ext));
      if (!r.wr)
         chk_val(rsp_rdata, r.b8 ? {8'h0, a[7:0]} : {~a[7:0], a[7:0]});
   endtask : go
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (10) @(negedge clk_sys);
      chk_pins(pins, 12'hffc);
      chk_val({doe, rsp_valid, req_ready}, 3'h1);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk_val(boot_target_nand, 1'b1);
      for (int i = 0; i < 10; i++)
         go(rows[i], 24'h3c5a11 + 24'(i) * 24'h010203, 16'hc3a5 ^ 16'(i * 4369),
            4'h0);
      go(rows[0], 24'h00a0f1, 16'h0, 4'h2);
      go(rows[3], 24'h3fe703, 16'h0, 4'h3);
      // reset in mid-access with the other boot strap
      @(posedge clk_sys);
      {req_target, req_bank, req_write, req_valid} <= {4'h0, 1'b0, 1'b1};
      boot_from_nand <= 1'b0;
      repeat (3) @(posedge clk_sys);
      req_valid <= 1'b0;
      #2 rst_n = 1'b0;
      #1 chk_pins(pins, 12'hffc);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk_val(boot_target_nand, 1'b0);
      go(rows[1], 24'h12ab34, 16'h5aa5, 4'h0);
      print_verdict();
   end
endmodule : embp_port_tb_top
